// *** rtwoc_ext_div.sv ***
// Purpose: Synchronise the external oscillator and divide it by eight
// Assumes: Oscillator well below half the system clock rate
// Notes: Emits one pulse per falling edge of the divided clock
`timescale 1ns/1ps
`default_nettype none
module rtwoc_ext_div #(
	parameter int DIV = rtwoc_pkg::EXT_DIV
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Oscillator pin
	input wire logic ext_osc,
	// Divided clock falling-edge pulse
	output logic fall_tick
);
	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic sync1_r;
	logic sync2_r;
	logic prev_r;
	logic [CW-1:0] div_r;
	logic rise;

	// Two-stage synchroniser; only the second stage feeds logic
	always_ff @(posedge clk) begin
		if (srst) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			sync1_r <= ext_osc;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	assign rise = sync2_r & ~prev_r;

	// Top bit of the count falls as it wraps to zero
	always_ff @(posedge clk) begin
		if (srst) begin
			div_r <= '0;
			fall_tick <= 1'b0;
		end else begin
			fall_tick <= rise && (div_r == LAST);
			if (rise) begin
				div_r <= (div_r == LAST) ? '0 : CW'(div_r + 1'b1);
			end
		end
	end
endmodule // rtwoc_ext_div
`default_nettype wire

// *** rtwoc_pkg.sv ***
// Purpose: Shared constants for the reload timer with oscillator capture
// Assumes: Registers reached over AXI4-Lite, one aligned word per register index
// Notes: Byte address of a register is four times its index
package rtwoc_pkg;
	// Register indices
	localparam logic [7:0] IDX_TIMER_CONTROL = 8'h91;
	localparam logic [7:0] IDX_RELOAD_LOW = 8'h92;
	localparam logic [7:0] IDX_RELOAD_HIGH = 8'h93;
	localparam logic [7:0] IDX_COUNTER_LOW = 8'h94;
	localparam logic [7:0] IDX_COUNTER_HIGH = 8'h95;
	localparam logic [7:0] IDX_CLOCK_INT_CTL = 8'h96;

	// Control register fields
	localparam int CTL_HIGH_OVF = 7;
	localparam int CTL_LOW_OVF = 6;
	localparam int CTL_LOW_INT_EN = 5;
	localparam int CTL_CAPTURE_EN = 4;
	localparam int CTL_SPLIT = 3;
	localparam int CTL_RUN = 2;
	localparam int CTL_EXT_CLK = 0;

	// Clock and interrupt control fields
	localparam int AUX_LOW_FAST = 0;
	localparam int AUX_HIGH_FAST = 1;
	localparam int AUX_INT_EN = 2;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;

	// Prescaler and divider counts
	localparam int SYS_DIV = 12;
	localparam int EXT_DIV = 8;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** rtwoc_timer.sv ***
// Purpose: 16-bit auto-reload timer, splittable in two 8-bit timers, with osc capture
// Assumes: AXI4-Lite register access, ext_osc asynchronous to clk
// Notes: timer_irq is a level request held while an enabled flag is set
// Overview of operation
// - Split bit clear runs one 16-bit up-counter with automatic reload.
// - 16-bit wrap from all ones loads reload pair and sets high flag.
// - Timer interrupt enabled requests interrupt on every 16-bit overflow.
// - In 16-bit mode, low interrupt enable adds a request per low-byte wrap.
// - Split mode runs two 8-bit counters, each reloading from its own byte.
// - In split mode run control gates only the high counter.
// - Run bit set starts the 16-bit or high counter, cleared stops it.
// - Per half: fast bit picks system clock, else div-12 or external div-8.
// - One external select bit serves both halves; fast bits override per half.
// - External div-8 source is synchronised to the system clock before use.
// - High and low flags set on their byte wrapping from FF to 00 or to its reload value.
// - Low flag sets on every low-byte wrap in either mode.
// - Split mode requests on high wraps, and on either when low enable set.
// - Flags never clear by hardware; software clears them and checks both.
// - Capture enable bit turns oscillator capture mode off or on.
// - Capture event on each falling edge of external clock divided by eight.
// - Capture copies the 16-bit count into reload pair and sets high flag.
// - In capture mode the low half uses system clock or div-12 via low fast bit.
// - Control bit 1 reads zero and ignores writes.
`timescale 1ns/1ps
`default_nettype none
module rtwoc_timer #(
	parameter int AW = 12
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	// AXI4-Lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// External oscillator pin
	input wire logic ext_osc,
	// Interrupt request to the processor
	output logic timer_irq
);
	localparam int PW = $clog2(rtwoc_pkg::SYS_DIV);
	localparam logic [PW-1:0] PRE_LAST = PW'(rtwoc_pkg::SYS_DIV - 1);

	// Word index from a byte address; low two bits are ignored
	function automatic logic [7:0] reg_index(input logic [AW-1:0] addr);
		reg_index = addr[9:2];
	endfunction

	function automatic logic is_mapped(input logic [7:0] idx);
		is_mapped = (idx >= rtwoc_pkg::IDX_TIMER_CONTROL) &&
			(idx <= rtwoc_pkg::IDX_CLOCK_INT_CTL);
	endfunction

	// Control state
	logic high_ovf_r;
	logic low_ovf_r;
	logic low_int_en_r;
	logic cap_en_r;
	logic split_r;
	logic run_r;
	logic xclk_r;
	logic lo_fast_r;
	logic hi_fast_r;
	logic int_en_r;
	logic [7:0] rl_lo_r;
	logic [7:0] rl_hi_r;
	logic [7:0] cnt_lo_r;
	logic [7:0] cnt_hi_r;
	logic [7:0] cnt_lo_nxt;
	logic [7:0] cnt_hi_nxt;
	logic lo_wrap;
	logic hi_wrap;

	// Bus state
	logic aw_held_r;
	logic w_held_r;
	logic [7:0] aw_idx_r;
	logic [7:0] w_byte_r;
	logic w_lane0_r;
	logic [7:0] rd_idx_r;
	logic wr_fire;
	logic wr_en;
	logic [7:0] rd_byte;

	// Tick sources
	logic [PW-1:0] pre_r;
	logic div12_tick;
	logic ext_tick;
	logic lo_tick;
	logic hi_tick;
	logic cap_evt;

	// external div-8 source synchronised before use
	rtwoc_ext_div #(
		.DIV(rtwoc_pkg::EXT_DIV)
	) u_ext_div (
		.clk(clk),
		.srst(srst),
		.ext_osc(ext_osc),
		.fall_tick(ext_tick)
	);

	always_ff @(posedge clk) begin
		if (srst) begin
			pre_r <= '0;
		end else begin
			pre_r <= (pre_r == PRE_LAST) ? '0 : PW'(pre_r + 1'b1);
		end
	end

	assign div12_tick = (pre_r == PRE_LAST);

	// per-half source; one external select for both halves
	// capture mode keeps the low half off the measured clock
	always_comb begin
		if (lo_fast_r) begin
			lo_tick = 1'b1;
		end else if (xclk_r && !cap_en_r) begin
			lo_tick = ext_tick;
		end else begin
			lo_tick = div12_tick;
		end
		if (hi_fast_r) begin
			hi_tick = 1'b1;
		end else if (xclk_r) begin
			hi_tick = ext_tick;
		end else begin
			hi_tick = div12_tick;
		end
	end

	// capture only while enabled; on divided-clock falling edge
	assign cap_evt = cap_en_r & ext_tick;

	// AXI write: address and data taken in either order
	assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
	assign wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid;
	assign wr_en = wr_fire & w_lane0_r;

	always_ff @(posedge clk) begin
		if (srst) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_idx_r <= rtwoc_pkg::RST_BYTE;
			w_byte_r <= rtwoc_pkg::RST_BYTE;
			w_lane0_r <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= rtwoc_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_idx_r <= reg_index(s_axi_awaddr);
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				w_byte_r <= s_axi_wdata[7:0];
				w_lane0_r <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= is_mapped(aw_idx_r) ? rtwoc_pkg::RESP_OKAY :
					rtwoc_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	function automatic logic wr_hit(input logic [7:0] idx);
		wr_hit = wr_en && (aw_idx_r == idx);
	endfunction

	// bit 1 of control is not stored and reads zero
	always_comb begin
		unique case (reg_index(s_axi_araddr))
			rtwoc_pkg::IDX_TIMER_CONTROL: begin
				rd_byte = {high_ovf_r, low_ovf_r, low_int_en_r, cap_en_r,
					split_r, run_r, 1'b0, xclk_r};
			end
			rtwoc_pkg::IDX_RELOAD_LOW: rd_byte = rl_lo_r;
			rtwoc_pkg::IDX_RELOAD_HIGH: rd_byte = rl_hi_r;
			rtwoc_pkg::IDX_COUNTER_LOW: rd_byte = cnt_lo_r;
			rtwoc_pkg::IDX_COUNTER_HIGH: rd_byte = cnt_hi_r;
			rtwoc_pkg::IDX_CLOCK_INT_CTL: rd_byte = {5'h0, int_en_r, hi_fast_r, lo_fast_r};
			default: rd_byte = rtwoc_pkg::RST_BYTE;
		endcase
	end

	// AXI read: one outstanding, answer one cycle after address
	assign s_axi_arready = ~s_axi_rvalid;

	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= rtwoc_pkg::RESP_OKAY;
			rd_idx_r <= rtwoc_pkg::RST_BYTE;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h00_0000, rd_byte};
			rd_idx_r <= reg_index(s_axi_araddr);
			s_axi_rresp <= is_mapped(reg_index(s_axi_araddr)) ? rtwoc_pkg::RESP_OKAY :
				rtwoc_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Configuration bits
	always_ff @(posedge clk) begin
		if (srst) begin
			low_int_en_r <= 1'b0;
			cap_en_r <= 1'b0;
			split_r <= 1'b0;
			run_r <= 1'b0;
			xclk_r <= 1'b0;
			lo_fast_r <= 1'b0;
			hi_fast_r <= 1'b0;
			int_en_r <= 1'b0;
		end else begin
			if (wr_hit(rtwoc_pkg::IDX_TIMER_CONTROL)) begin
				low_int_en_r <= w_byte_r[rtwoc_pkg::CTL_LOW_INT_EN];
				cap_en_r <= w_byte_r[rtwoc_pkg::CTL_CAPTURE_EN];
				split_r <= w_byte_r[rtwoc_pkg::CTL_SPLIT];
				run_r <= w_byte_r[rtwoc_pkg::CTL_RUN];
				xclk_r <= w_byte_r[rtwoc_pkg::CTL_EXT_CLK];
			end
			if (wr_hit(rtwoc_pkg::IDX_CLOCK_INT_CTL)) begin
				lo_fast_r <= w_byte_r[rtwoc_pkg::AUX_LOW_FAST];
				hi_fast_r <= w_byte_r[rtwoc_pkg::AUX_HIGH_FAST];
				int_en_r <= w_byte_r[rtwoc_pkg::AUX_INT_EN];
			end
		end
	end

	// Counter next value
	always_comb begin
		cnt_lo_nxt = cnt_lo_r;
		cnt_hi_nxt = cnt_hi_r;
		lo_wrap = 1'b0;
		hi_wrap = 1'b0;
		if (!split_r) begin
			// single 16-bit counter; runs only while run is set
			// whole counter steps on the low-half tick
			if (run_r && lo_tick) begin
				lo_wrap = (cnt_lo_r == 8'hFF);
				if ({cnt_hi_r, cnt_lo_r} == 16'hFFFF) begin
					// reload pair loaded on 16-bit wrap
					{cnt_hi_nxt, cnt_lo_nxt} = {rl_hi_r, rl_lo_r};
					hi_wrap = 1'b1;
				end else begin
					{cnt_hi_nxt, cnt_lo_nxt} = 16'({cnt_hi_r, cnt_lo_r} + 16'h0001);
				end
			end
		end else begin
			// two 8-bit counters; low half free-running
			if (lo_tick) begin
				lo_wrap = (cnt_lo_r == 8'hFF);
				cnt_lo_nxt = lo_wrap ? rl_lo_r : 8'(cnt_lo_r + 8'h01);
			end
			if (run_r && hi_tick) begin
				hi_wrap = (cnt_hi_r == 8'hFF);
				cnt_hi_nxt = hi_wrap ? rl_hi_r : 8'(cnt_hi_r + 8'h01);
			end
		end
	end

	// Software write to a counter byte takes that cycle's place
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_lo_r <= rtwoc_pkg::RST_BYTE;
			cnt_hi_r <= rtwoc_pkg::RST_BYTE;
		end else begin
			cnt_lo_r <= wr_hit(rtwoc_pkg::IDX_COUNTER_LOW) ? w_byte_r : cnt_lo_nxt;
			cnt_hi_r <= wr_hit(rtwoc_pkg::IDX_COUNTER_HIGH) ? w_byte_r : cnt_hi_nxt;
		end
	end

	// capture copies count into reload pair, over any software write
	always_ff @(posedge clk) begin
		if (srst) begin
			rl_lo_r <= rtwoc_pkg::RST_BYTE;
			rl_hi_r <= rtwoc_pkg::RST_BYTE;
		end else if (cap_evt) begin
			rl_lo_r <= cnt_lo_r;
			rl_hi_r <= cnt_hi_r;
		end else begin
			if (wr_hit(rtwoc_pkg::IDX_RELOAD_LOW)) begin
				rl_lo_r <= w_byte_r;
			end
			if (wr_hit(rtwoc_pkg::IDX_RELOAD_HIGH)) begin
				rl_hi_r <= w_byte_r;
			end
		end
	end

	// flags set on wraps; only software clears them
	// A hardware set wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			high_ovf_r <= 1'b0;
			low_ovf_r <= 1'b0;
		end else begin
			high_ovf_r <= (wr_hit(rtwoc_pkg::IDX_TIMER_CONTROL) ?
				w_byte_r[rtwoc_pkg::CTL_HIGH_OVF] : high_ovf_r) | hi_wrap | cap_evt;
			low_ovf_r <= (wr_hit(rtwoc_pkg::IDX_TIMER_CONTROL) ?
				w_byte_r[rtwoc_pkg::CTL_LOW_OVF] : low_ovf_r) | lo_wrap;
		end
	end

	// level request from the enabled flags
	assign timer_irq = int_en_r & (high_ovf_r | (low_int_en_r & low_ovf_r));

	a_wrap_reload: assert property (@(posedge clk) disable iff (srst)
		(!split_r && run_r && lo_tick && {cnt_hi_r, cnt_lo_r} == 16'hFFFF &&
		!wr_hit(rtwoc_pkg::IDX_COUNTER_LOW) && !wr_hit(rtwoc_pkg::IDX_COUNTER_HIGH))
		|=> {cnt_hi_r, cnt_lo_r} == {$past(rl_hi_r), $past(rl_lo_r)})
		else $error("16-bit wrap did not reload");
	// high flag follows a high wrap
	a_high_flag_set: assert property (@(posedge clk) disable iff (srst)
		hi_wrap |=> high_ovf_r)
		else $error("high flag missed a wrap");
	// low flag follows a low wrap
	a_low_flag_set: assert property (@(posedge clk) disable iff (srst)
		lo_wrap |=> low_ovf_r)
		else $error("low flag missed a wrap");
	// flag stays set without a control write
	a_flag_sticky: assert property (@(posedge clk) disable iff (srst)
		(high_ovf_r && low_ovf_r && !wr_hit(rtwoc_pkg::IDX_TIMER_CONTROL))
		|=> high_ovf_r && low_ovf_r)
		else $error("flag cleared by hardware");
	// low half counts with run clear in split mode
	a_split_low_free: assert property (@(posedge clk) disable iff (srst)
		(split_r && !run_r && lo_tick && cnt_lo_r != 8'hFF &&
		!wr_hit(rtwoc_pkg::IDX_COUNTER_LOW) && !wr_hit(rtwoc_pkg::IDX_COUNTER_HIGH))
		|=> cnt_lo_r == 8'($past(cnt_lo_r) + 8'h01) && $stable(cnt_hi_r))
		else $error("split low half did not free-run");
	a_stop_holds: assert property (@(posedge clk) disable iff (srst)
		(!split_r && !run_r && !wr_hit(rtwoc_pkg::IDX_COUNTER_LOW) &&
		!wr_hit(rtwoc_pkg::IDX_COUNTER_HIGH)) |=> $stable({cnt_hi_r, cnt_lo_r}))
		else $error("stopped counter moved");
	// capture loads the count and raises the high flag
	a_capture_load: assert property (@(posedge clk) disable iff (srst)
		cap_evt |=> {rl_hi_r, rl_lo_r} == $past({cnt_hi_r, cnt_lo_r}) && high_ovf_r)
		else $error("capture did not load reload pair");
	a_irq_high: assert property (@(posedge clk) disable iff (srst)
		(int_en_r && hi_wrap) |=> timer_irq)
		else $error("no request after high wrap");
	// low flag requests only with low enable
	a_irq_low_gate: assert property (@(posedge clk) disable iff (srst)
		(!high_ovf_r && !low_int_en_r) |-> !timer_irq)
		else $error("request without enabled source");
	a_ctl_bit1_zero: assert property (@(posedge clk) disable iff (srst)
		(s_axi_rvalid && rd_idx_r == rtwoc_pkg::IDX_TIMER_CONTROL) |-> !s_axi_rdata[1])
		else $error("unused control bit read nonzero");
endmodule // rtwoc_timer
`default_nettype wire

// *** rtwoc_timer_test.sv ***
// Purpose: Self-checking bench for the reload timer through its register bus
// Assumes: Oscillator half period of 3 to 5 clocks, so eight rises fit in 80 clocks
// Notes: Counts that hang on oscillator phase are judged only through flags
`timescale 1ns/1ps
`default_nettype none
module rtwoc_timer_test;
	localparam logic [7:0] CTL = rtwoc_pkg::IDX_TIMER_CONTROL;
	localparam logic [7:0] RLL = rtwoc_pkg::IDX_RELOAD_LOW;
	localparam logic [7:0] RLH = rtwoc_pkg::IDX_RELOAD_HIGH;
	localparam logic [7:0] CNL = rtwoc_pkg::IDX_COUNTER_LOW;
	localparam logic [7:0] CNH = rtwoc_pkg::IDX_COUNTER_HIGH;
	localparam logic [7:0] AUX = rtwoc_pkg::IDX_CLOCK_INT_CTL;
	localparam logic [1:0] OK = rtwoc_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = rtwoc_pkg::RESP_SLVERR;
	logic clk, srst, awvalid, wvalid, bready, arvalid, rready, ext_osc;
	logic awready, wready, bvalid, arready, rvalid, timer_irq;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	int fails = 0;
	int compares = 0;
	int seed = 32'h97ed3cd4;
	logic [1:0] exp_b[$];
	logic [33:0] exp_r[$];

	rtwoc_timer #(.AW(12)) dut (
		.clk(clk), .srst(srst),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .ext_osc(ext_osc), .timer_irq(timer_irq)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Random half period keeps the divider off any fixed phase
	initial begin
		int half;
		ext_osc = 1'b0;
		forever begin
			half = 3 + ($unsigned($random(seed)) % 3);
			repeat (half) @(posedge clk);
			ext_osc <= ~ext_osc;
		end
	end

	task automatic complete_run();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask // complete_run

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask // check

	task automatic guard(inout int n);
		n++;
		if (n > 60) begin
			fails++;
			$display("ERROR %0t: bus wait ran out", $time);
			complete_run();
		end
	endtask // guard

	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] resp);
		int n;
		bit ta, tw, tb;
		n = 0;
		ta = 0;
		tw = 0;
		@(posedge clk);
		exp_b.push_back(resp);
		awaddr <= {2'b00, idx, 2'b00};
		wdata <= {24'h00_0000, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ta && tw)) begin
			@(negedge clk);
			if (!ta && awready) begin
				ta = 1;
				@(posedge clk);
				awvalid <= 1'b0;
				if (!tw && wready) tw = 1;
			end else begin
				if (!tw && wready) tw = 1;
				@(posedge clk);
			end
			if (tw) wvalid <= 1'b0;
			guard(n);
		end
		do begin
			@(negedge clk);
			tb = bvalid;
			@(posedge clk);
			guard(n);
		end while (!tb);
		bready <= 1'b0;
	endtask // wr

	task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] resp);
		int n;
		bit t;
		n = 0;
		@(posedge clk);
		exp_r.push_back({resp, 24'h00_0000, d});
		araddr <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			t = arready;
			@(posedge clk);
			guard(n);
		end while (!t);
		arvalid <= 1'b0;
		do begin
			@(negedge clk);
			t = rvalid;
			@(posedge clk);
			guard(n);
		end while (!t);
		rready <= 1'b0;
	endtask // rd

	task automatic irq_is(input logic e);
		@(negedge clk);
		check({31'h0, timer_irq}, {31'h0, e}, "timer_irq");
	endtask // irq_is

	// Results are judged where they appear, against the oldest note
	always @(negedge clk) begin : monitor
		logic [33:0] e;
		if (bvalid && bready) begin
			if (exp_b.size() == 0) check(32'h1, 32'h0, "stray write response");
			else check({30'h0, bresp}, {30'h0, exp_b.pop_front()}, "bresp");
		end
		if (rvalid && rready) begin
			if (exp_r.size() == 0) e = 34'h3_ffff_ffff;
			else e = exp_r.pop_front();
			check({30'h0, rresp}, {30'h0, e[33:32]}, "rresp");
			check(rdata, e[31:0], "rdata");
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		$display("ERROR %0t: watchdog expired", $time);
		complete_run();
	end

	initial begin
		int i;
		logic [7:0] d;
		srst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h0000_0000;
		wstrb = 4'h0;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		for (i = 0; i < 6; i++) rd(CTL + 8'(i), 8'h00, OK);
		rd(8'h90, 8'h00, ERR);
		wr(8'h97, 8'hff, ERR);
		wr(CTL, 8'h02, OK);
		rd(CTL, 8'h00, OK);
		d = 8'($random(seed));
		wr(RLL, d, OK);
		rd(RLL, d, OK);
		d = 8'($random(seed));
		wr(RLH, d, OK);
		rd(RLH, d, OK);
		$display("test registers done");
		// Full 16-bit wrap on the fast source
		wr(AUX, 8'h05, OK);
		wr(CNL, 8'hfe, OK);
		wr(CNH, 8'hff, OK);
		wr(RLL, 8'h00, OK);
		wr(RLH, 8'hab, OK);
		wr(CTL, 8'h04, OK);
		rd(CTL, 8'hc4, OK);
		rd(CNH, 8'hab, OK);
		irq_is(1'b1);
		repeat (50) @(posedge clk);
		rd(CTL, 8'hc4, OK);
		wr(CTL, 8'h00, OK);
		irq_is(1'b0);
		wr(CNL, 8'h33, OK);
		repeat (40) @(posedge clk);
		rd(CNL, 8'h33, OK);
		rd(CNH, 8'hab, OK);
		$display("test wrap done");
		// Divide-by-12 source, low wrap inside the 16-bit count
		wr(AUX, 8'h00, OK);
		wr(CNL, 8'hf8, OK);
		wr(CNH, 8'h00, OK);
		wr(CTL, 8'h04, OK);
		repeat (40) @(posedge clk);
		rd(CTL, 8'h04, OK);
		repeat (120) @(posedge clk);
		rd(CTL, 8'h44, OK);
		rd(CNH, 8'h01, OK);
		wr(AUX, 8'h04, OK);
		irq_is(1'b0);
		wr(CTL, 8'h64, OK);
		irq_is(1'b1);
		wr(CTL, 8'h00, OK);
		$display("test prescale done");
		// Oscillator divided by eight needs at least 48 clocks per tick
		wr(AUX, 8'h00, OK);
		wr(CNL, 8'hfc, OK);
		wr(CTL, 8'h05, OK);
		repeat (60) @(posedge clk);
		rd(CTL, 8'h05, OK);
		repeat (500) @(posedge clk);
		rd(CTL, 8'h45, OK);
		wr(CTL, 8'h00, OK);
		$display("test oscillator done");
		// Split mode with run control off for the low half
		wr(AUX, 8'h02, OK);
		wr(RLL, 8'h00, OK);
		wr(RLH, 8'hff, OK);
		wr(CNH, 8'h10, OK);
		wr(CNL, 8'hfe, OK);
		wr(CTL, 8'h08, OK);
		repeat (60) @(posedge clk);
		rd(CTL, 8'h48, OK);
		rd(CNH, 8'h10, OK);
		wr(AUX, 8'h06, OK);
		irq_is(1'b0);
		wr(CTL, 8'h68, OK);
		irq_is(1'b1);
		wr(CTL, 8'h0c, OK);
		// High half needs 240 fast ticks from 0x10 before its first wrap
		repeat (250) @(posedge clk);
		rd(CNH, 8'hff, OK);
		rd(CTL, 8'h8c, OK);
		irq_is(1'b1);
		// Reload of 0xff wraps every tick, so the stopping write loses to the set
		wr(CTL, 8'h08, OK);
		irq_is(1'b1);
		wr(CTL, 8'h08, OK);
		irq_is(1'b0);
		// One external select drives the low half; div-12 would wrap within 24 clocks
		wr(CTL, 8'h09, OK);
		wr(CNL, 8'hfe, OK);
		repeat (28) @(posedge clk);
		rd(CTL, 8'h09, OK);
		repeat (200) @(posedge clk);
		rd(CTL, 8'h49, OK);
		$display("test split done");
		// Capture off, then on, with the count held below a byte carry
		// capture kept in 16-bit mode on the fast count clock
		wr(CTL, 8'h00, OK);
		wr(AUX, 8'h01, OK);
		wr(RLL, 8'h77, OK);
		wr(RLH, 8'h77, OK);
		wr(CNL, 8'h00, OK);
		wr(CNH, 8'h40, OK);
		wr(CTL, 8'h04, OK);
		repeat (110) @(posedge clk);
		rd(CTL, 8'h04, OK);
		rd(RLH, 8'h77, OK);
		wr(CTL, 8'h00, OK);
		wr(CNL, 8'h00, OK);
		wr(CNH, 8'h40, OK);
		wr(CTL, 8'h14, OK);
		repeat (100) @(posedge clk);
		rd(CTL, 8'h94, OK);
		wr(CTL, 8'h00, OK);
		rd(RLH, 8'h40, OK);
		$display("test capture done");
		repeat (5) @(posedge clk);
		complete_run();
	end
endmodule // rtwoc_timer_test
`default_nettype wire
